// ---- hdl/adc_conv_pkg.sv ----
package adc_conv_pkg;

  localparam int DATA_W          = 12;
  localparam int DATA_MSB        = DATA_W - 1;
  localparam int LATENCY_DEF     = 6;
  localparam int REF_LAT_MIN     = 8;
  localparam int REF_LAT_MAX     = 10;
  localparam int CLK_PERIOD_NS   = 100;
  localparam int SETTLE_US       = 500;
  localparam int SETTLE_CYCLES   = SETTLE_US * 1000 / CLK_PERIOD_NS;
  localparam int SETTLE_W        = 16;
  localparam logic SRC_INTERNAL  = 1'b0;
  localparam logic SRC_EXTERNAL  = 1'b1;
  localparam logic RANGE_2VPP    = 1'b0;
  localparam logic RANGE_3VPP    = 1'b1;
  localparam logic [11:0] CODE_POS_FS   = 12'hfff;
  localparam logic [11:0] CODE_POS_HALF = 12'hc00;
  localparam logic [11:0] CODE_ZERO     = 12'h800;
  localparam logic [11:0] CODE_NEG_HALF = 12'h400;
  localparam logic [11:0] CODE_NEG_FS   = 12'h000;
  // Signed analog sample scale: 3 Vp-p span is +-1536 units, 2 Vp-p +-1024
  localparam int AIN_W           = 14;
  localparam logic signed [13:0] HALF_SPAN_2V = 14'sh0400;
  localparam logic signed [13:0] HALF_SPAN_3V = 14'sh0600;

endpackage : adc_conv_pkg

// ---- hdl/adc_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  import adc_conv_pkg::*;
  logic [DATA_W-1:0] offsetBinaryCode;
  logic              outOfRangeFlag;
  logic              referenceSourceSelect;
  logic              referenceSourceSelectOe;
  logic              rangeSelectPin;
  logic              rangeSelectPinOe;

  modport converter (
    output offsetBinaryCode,
    output outOfRangeFlag,
    input  referenceSourceSelect,
    input  referenceSourceSelectOe,
    input  rangeSelectPin,
    input  rangeSelectPinOe
  );

  modport receiver (
    input  offsetBinaryCode,
    input  outOfRangeFlag,
    output referenceSourceSelect,
    output referenceSourceSelectOe,
    output rangeSelectPin,
    output rangeSelectPinOe
  );
endinterface : adc_link_if
`default_nettype wire

// ---- hdl/adc_converter.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_converter
  import adc_conv_pkg::*;
#(
  parameter int LATENCY = LATENCY_DEF,
  parameter int REF_LAT = REF_LAT_MIN
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic signed [AIN_W-1:0]  analogIn,
  input  wire logic signed [AIN_W-1:0]  extHalfSpan,
  adc_link_if.converter                 link
);

  // Reference delay and data pipe add up to REF_LAT at the outputs if REF_LAT > LATENCY, else to LATENCY + 1
  localparam int REF_DEPTH = (REF_LAT > LATENCY) ? REF_LAT - LATENCY : 1;

  typedef struct packed {
    logic [LATENCY-1:0][DATA_W-1:0] dataPipe;
    logic [LATENCY-1:0]             flagPipe;
    logic [REF_DEPTH-1:0][AIN_W-1:0] refPipe;
  } state_s;

  state_s cur;
  state_s next_cur;

  logic                    extMode;
  logic                    wide;
  logic signed [AIN_W-1:0] halfSpan;
  logic signed [AIN_W-1:0] refDelayed;
  logic signed [AIN_W+1:0] shifted;
  logic [DATA_W-1:0]       code;
  logic                    over;

  function automatic logic pinLevel(input logic value, input logic oe,
                                    input logic pull);
    pinLevel = oe ? value : pull;
  endfunction : pinLevel

  always_comb begin
    extMode = pinLevel(link.referenceSourceSelect,
                       link.referenceSourceSelectOe, SRC_EXTERNAL);
    wide = pinLevel(link.rangeSelectPin, link.rangeSelectPinOe,
                    RANGE_2VPP);
    refDelayed = $signed(cur.refPipe[REF_DEPTH-1]);
    if (extMode == SRC_EXTERNAL) begin
      halfSpan = refDelayed;
    end else begin
      halfSpan = wide ? HALF_SPAN_3V : HALF_SPAN_2V;
    end
    over = 1'b0;
    code = CODE_ZERO;
    shifted = '0;
    if (halfSpan <= 0) begin
      over = 1'b1;
    end else if (analogIn >= halfSpan) begin
      over = 1'b1;
      code = CODE_POS_FS;
    end else if (analogIn < -halfSpan) begin
      over = 1'b1;
      code = CODE_NEG_FS;
    end else begin
      // Scale to 12 bits: (x + h) * 2048 / h
      shifted = (AIN_W+2)'(((32'(analogIn) + 32'(halfSpan)) <<< 11)
                / 32'(halfSpan));
      code = shifted[DATA_W-1:0];
    end
    next_cur = cur;
    next_cur.refPipe[0] = extHalfSpan;
    for (int i = 1; i < REF_DEPTH; i++) begin
      next_cur.refPipe[i] = cur.refPipe[i-1];
    end
    next_cur.dataPipe[0] = code;
    next_cur.flagPipe[0] = over;
    for (int i = 1; i < LATENCY; i++) begin
      next_cur.dataPipe[i] = cur.dataPipe[i-1];
      next_cur.flagPipe[i] = cur.flagPipe[i-1];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign link.offsetBinaryCode = cur.dataPipe[LATENCY-1];
  assign link.outOfRangeFlag   = cur.flagPipe[LATENCY-1];

endmodule : adc_converter
`default_nettype wire

// ---- hdl/adc_receiver.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_receiver
  import adc_conv_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              useExternal,
  input  wire logic              useWideRange,
  input  wire logic              releasePins,
  output logic [DATA_W-1:0]      sampleOffset,
  output logic [DATA_W-1:0]      sampleSigned,
  output logic                   sampleOver,
  output logic                   sampleValid,
  adc_link_if.receiver           link
);

  typedef struct packed {
    logic [DATA_W-1:0]   offset;
    logic [DATA_W-1:0]   twos;
    logic                over;
    logic                valid;
    logic                src;
    logic                rng;
    logic                oe;
    logic [SETTLE_W-1:0] settleLeft;
  } state_s;

  state_s cur;
  state_s next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.src = useExternal;
    next_cur.rng = useWideRange;
    next_cur.oe = ~releasePins;
    next_cur.offset = link.offsetBinaryCode;
    next_cur.twos = {~link.offsetBinaryCode[DATA_MSB],
                     link.offsetBinaryCode[DATA_MSB-1:0]};
    next_cur.over = link.outOfRangeFlag;
    // Any configuration change restarts the settling wait
    if (next_cur.src != cur.src || next_cur.rng != cur.rng
        || next_cur.oe != cur.oe) begin
      next_cur.settleLeft = SETTLE_W'(SETTLE);
    end else if (cur.settleLeft != '0) begin
      next_cur.settleLeft = cur.settleLeft - 1'b1;
    end
    next_cur.valid = (cur.settleLeft == '0)
                     && (next_cur.settleLeft == '0);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
      cur.settleLeft <= SETTLE_W'(SETTLE);
      cur.oe <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign link.referenceSourceSelect   = cur.src;
  assign link.referenceSourceSelectOe = cur.oe;
  assign link.rangeSelectPin          = cur.rng;
  assign link.rangeSelectPinOe        = cur.oe;
  assign sampleOffset = cur.offset;
  assign sampleSigned = cur.twos;
  assign sampleOver   = cur.over;
  assign sampleValid  = cur.valid;

endmodule : adc_receiver
`default_nettype wire

// ---- verification/adc_link_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_link_checker
  import adc_conv_pkg::*;
#(
  parameter int LATENCY = LATENCY_DEF
) (
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic signed [AIN_W-1:0] analogIn,
  input wire logic [DATA_W-1:0]       offsetBinaryCode,
  input wire logic                    outOfRangeFlag,
  input wire logic                    referenceSourceSelect,
  input wire logic                    referenceSourceSelectOe,
  input wire logic                    rangeSelectPin,
  input wire logic                    rangeSelectPinOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic signed [AIN_W-1:0] x;
  logic [DATA_W-1:0]       c;
  logic                    f;
  logic                    nar;
  logic                    wid;
  logic                    intRef;
  assign x = analogIn;
  assign c = offsetBinaryCode;
  assign f = outOfRangeFlag;
  assign intRef = referenceSourceSelectOe && !referenceSourceSelect;
  // Undriven range pin reads low
  assign nar = intRef && !(rangeSelectPinOe && rangeSelectPin);
  assign wid = intRef && rangeSelectPinOe && rangeSelectPin;
  property p_zero; x == 0 |-> ##LATENCY c == 12'h800 && !f; endproperty
  a_zero: assert property (p_zero) else $error("zero code");
  property p_over; x > 14'sd2048 |-> ##LATENCY f && c == 12'hfff; endproperty
  a_over: assert property (p_over) else $error("over high");
  property p_undr; x < -14'sd2048 |-> ##LATENCY f && c == 12'h000; endproperty
  a_undr: assert property (p_undr) else $error("over low");
  property p_in; nar && x > -14'sd900 && x < 14'sd900 |-> ##LATENCY !f;
  endproperty
  a_in: assert property (p_in) else $error("flag in range");
  property p_h2; nar && x == 14'sd512 |-> ##LATENCY c == 12'hc00; endproperty
  a_h2: assert property (p_h2) else $error("half 2V");
  property p_n2; nar && x == -14'sd512 |-> ##LATENCY c == 12'h400; endproperty
  a_n2: assert property (p_n2) else $error("neg half");
  property p_h3; wid && x == 14'sd768 |-> ##LATENCY c == 12'hc00; endproperty
  a_h3: assert property (p_h3) else $error("half 3V");
  property p_pair; f |-> c == 12'hfff || c == 12'h000; endproperty
  a_pair: assert property (p_pair) else $error("flag code");
endmodule : adc_link_checker
`default_nettype wire

// ---- verification/adc_sample_output_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_sample_output_control_tb_top
  import adc_conv_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, useExt = 1'b0, wide = 1'b0, rel = 1'b0;
  logic signed [AIN_W-1:0] ain = '0, hs = 14'sh0100;
  logic [DATA_W-1:0]       so, ss;
  logic                    ov, vld;
  int                      errCount = 0, nTests = 0;
  localparam int           SIM_SETTLE = 4;
  adc_link_if link ();
  adc_converter adc_converter_inst (.clk(clk), .nrst(nrst), .analogIn(ain),
    .extHalfSpan(hs), .link(link));
  adc_receiver #(.SETTLE(SIM_SETTLE)) adc_receiver_inst (.clk(clk),
    .nrst(nrst),
    .useExternal(useExt), .useWideRange(wide), .releasePins(rel),
    .sampleOffset(so), .sampleSigned(ss), .sampleOver(ov),
    .sampleValid(vld), .link(link));
  adc_link_checker #(.LATENCY(LATENCY_DEF)) adc_link_checker_inst (
    .clk(clk), .nrst(nrst), .analogIn(ain),
    .offsetBinaryCode(link.offsetBinaryCode),
    .outOfRangeFlag(link.outOfRangeFlag),
    .referenceSourceSelect(link.referenceSourceSelect),
    .referenceSourceSelectOe(link.referenceSourceSelectOe),
    .rangeSelectPin(link.rangeSelectPin),
    .rangeSelectPinOe(link.rangeSelectPinOe));
  always #50 clk = ~clk;
  task automatic check(input logic [DATA_W-1:0] seen, exp);
    nTests++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("errors %0d checks %0d", errCount, nTests);
    if (errCount == 0 && nTests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic conv(input logic signed [AIN_W-1:0] x,
                      input logic [DATA_W-1:0] e, input logic fl);
    @(posedge clk);
    ain <= x;
    repeat (LATENCY_DEF + 3) @(posedge clk);
    @(negedge clk);
    check(so, e);
    check(ss, {~e[DATA_W-1], e[DATA_W-2:0]});
    check({11'h000, ov}, {11'h000, fl});
  endtask : conv
  task automatic mode(input logic e, w, r);
    int n;
    @(posedge clk);
    ain <= '0;
    repeat (LATENCY_DEF + 2) @(posedge clk);
    useExt <= e;
    wide <= w;
    rel <= r;
    n = 0;
    repeat (2) @(negedge clk);
    while (vld !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check(12'(n == SIM_SETTLE + 1), 12'h001);
  endtask : mode
  task automatic t_narrow;
    conv(14'sd0, 12'h800, 1'b0);
    conv(14'sd512, 12'hc00, 1'b0);
    conv(-14'sd512, 12'h400, 1'b0);
    conv(14'sd2100, 12'hfff, 1'b1);
    conv(-14'sd2100, 12'h000, 1'b1);
  endtask : t_narrow
  task automatic t_wide;
    mode(1'b0, 1'b1, 1'b0);
    conv(14'sd768, 12'hc00, 1'b0);
    conv(14'sd1200, 12'he40, 1'b0);
  endtask : t_wide
  task automatic t_ext;
    int n;
    mode(1'b1, 1'b1, 1'b0);
    conv(14'sd128, 12'hc00, 1'b0);
    mode(1'b1, 1'b0, 1'b0);
    conv(14'sd256, 12'hfff, 1'b1);
    @(posedge clk);
    hs <= 14'sh0200;
    n = 0;
    @(negedge clk);
    while (link.offsetBinaryCode !== 12'hc00 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(12'(n >= REF_LAT_MIN && n <= REF_LAT_MAX), 12'h001);
  endtask : t_ext
  task automatic t_float;
    mode(1'b0, 1'b1, 1'b1);
    conv(14'sd256, 12'hc00, 1'b0);
  endtask : t_float
  initial begin
    #(100 * 3000);
    errCount++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (20) @(posedge clk);
    t_narrow();
    t_wide();
    t_ext();
    t_float();
    close_out();
  end
endmodule : adc_sample_output_control_tb_top
`default_nettype wire
